// file: common/sram_host_pkg.sv
package sram_host_pkg;
    // ==========================================================
    // array geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    // ==========================================================
    // clock, write and read timing, ns
    localparam int CLK_PERIOD_NS = 50;
    localparam int ADDR_SETUP_FALL_NS = 2;
    localparam int ADDR_SETUP_RISE_SLOW_NS = 34;
    localparam int STROBE_LOW_SLOW_NS = 25;
    localparam int DATA_SETUP_SLOW_NS = 20;
    localparam int HOLD_NS = 2;
    localparam int GATE_OFF_NS = 10;
    localparam int READ_ACCESS_SLOW_NS = 36;
    // least times round up to whole cycles, at least one
    localparam int SETUP_CYC = (ADDR_SETUP_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC_RAW =
        (ADDR_SETUP_RISE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (GATE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (READ_ACCESS_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_TURN, ST_ACCESS, ST_DONE
    } seq_state_t;
endpackage

// file: src/cycle_timer.sv
`timescale 1ns/100ps
// one-shot down counter, used as the phase timer of the sequencer
module cycle_timer #(
    parameter int CNT_W = 4
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // control
    input wire logic load_in,
    input wire logic [CNT_W-1:0] count_in,
    // status
    output logic expired_out
);
    logic [CNT_W-1:0] cnt_q;
    wire logic [CNT_W-1:0] cnt_d =
        load_in ? count_in : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) cnt_q <= '0;
        else cnt_q <= cnt_d;
    end
    // a count of n holds a phase n cycles; zero and one both end at once
    // expiry ignores load, else it would loop back through the sequencer
    assign expired_out = (cnt_q[CNT_W-1:1] == '0);
endmodule // cycle_timer

// file: src/sram_write_host.sv
`timescale 1ns/100ps
// Summary of operation
// RULE_01: select plus any strobe low writes
// RULE_02: address changes only with strobes high
// RULE_03: write starts when select and strobe meet
// RULE_04: write ends at first rising edge
// RULE_05: gate held high during writes, no contention
// RULE_06: data stable before strobe rises
// RULE_07: data held after strobe rises
// RULE_08: address valid before strobe falls
// RULE_09: address valid long before strobe rises
// RULE_10: strobe low pulse long enough
// RULE_11: address held after strobe rises
// RULE_12: select-controlled address setup before rise
// RULE_13: select-controlled select low long enough
// RULE_14: select-controlled data setup before rise
// RULE_15: select-controlled data/address hold after rise
// RULE_16: device re-drives no earlier than strobe rise
// RULE_17: select rising with strobes high stays hi-z
// RULE_18: select high means standby, hi-z
// RULE_19: lane strobes pick low/high byte
// RULE_20: one lane written, other read; host drives all sixteen data pins on every write
// RULE_21: strap high selects relaxed timing
// RULE_22: read gives all sixteen bits
// RULE_23: gate rising floats the data pins
// RULE_24: unstrobed lane keeps stored byte
module sram_write_host #(
    parameter int ADDR_W = sram_host_pkg::ADDR_W,
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // request side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic [1:0] req_lane_en_in,
    input wire logic guard_pin_strap_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    output logic relaxed_timing_select_out,
    // memory pins
    output logic [ADDR_W-1:0] word_addr_lines_out,
    output logic chip_select_n_out,
    output logic output_drive_gate_n_out,
    output logic byte_lane0_wr_strobe_out,
    output logic byte_lane1_wr_strobe_out,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic [DATA_W-1:0] data_pins_oe_out
);
    // ==========================================================
    // parameter checks
    if (ADDR_W != sram_host_pkg::ADDR_W || DATA_W != 2 * sram_host_pkg::LANE_W) begin : g_chk
        $error("sram_write_host: unsupported width");
    end

    // ==========================================================
    // state
    sram_host_pkg::seq_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q, rdata_q;
    logic [1:0] lane_q;
    logic write_q, cs_n_q, oe_n_q, drive_q, rsp_q, relaxed_q;
    logic [1:0] we_n_q;

    wire logic timer_done;
    wire logic timer_load;
    logic [sram_host_pkg::CNT_W-1:0] timer_count;

    // ==========================================================
    // decode
    wire logic take_req = (state_q == sram_host_pkg::ST_IDLE) && req_valid_in;
    // an all-zero lane mask is a no-op write; treat as full word
    wire logic [1:0] lane_sel = (req_lane_en_in == 2'h0) ? 2'h3 : req_lane_en_in;
    wire logic in_idle = (state_q == sram_host_pkg::ST_IDLE);
    assign timer_load = (state_q != state_d);

    always_comb begin
        state_d = state_q;
        timer_count = sram_host_pkg::CNT_ZERO;
        case (state_q)
            sram_host_pkg::ST_IDLE: begin
                if (req_valid_in) begin
                    state_d = req_write_in ? sram_host_pkg::ST_SETUP
                                           : sram_host_pkg::ST_ACCESS;
                    timer_count = req_write_in
                        ? sram_host_pkg::CNT_W'(sram_host_pkg::SETUP_CYC)
                        : sram_host_pkg::CNT_W'(sram_host_pkg::ACCESS_CYC);
                end
            end
            sram_host_pkg::ST_SETUP: begin
                // address and select settle before strobe falls
                if (timer_done) begin // RULE_08
                    state_d = sram_host_pkg::ST_STROBE;
                    timer_count = sram_host_pkg::CNT_W'(sram_host_pkg::STROBE_CYC);
                end
            end
            sram_host_pkg::ST_STROBE: begin
                // strobe pulse sized by the longest setup
                if (timer_done) begin // RULE_09 RULE_10 RULE_06
                    state_d = sram_host_pkg::ST_HOLD;
                    timer_count = sram_host_pkg::CNT_W'(sram_host_pkg::HOLD_CYC);
                end
            end
            sram_host_pkg::ST_HOLD: begin
                if (timer_done) begin // RULE_07 RULE_11
                    state_d = sram_host_pkg::ST_DONE;
                end
            end
            sram_host_pkg::ST_ACCESS: begin
                if (timer_done) begin // RULE_22
                    state_d = sram_host_pkg::ST_TURN;
                    timer_count = sram_host_pkg::CNT_W'(sram_host_pkg::TURN_CYC);
                end
            end
            sram_host_pkg::ST_TURN: begin
                // gate released; wait for device to float before reuse
                if (timer_done) begin // RULE_23
                    state_d = sram_host_pkg::ST_DONE;
                end
            end
            sram_host_pkg::ST_DONE: begin
                state_d = sram_host_pkg::ST_IDLE;
            end
            default: begin
                state_d = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // pin levels per next state
    wire logic nxt_cs = (state_d != sram_host_pkg::ST_IDLE) && (state_d != sram_host_pkg::ST_DONE);
    // strobes low only inside select; first rise ends the write
    wire logic nxt_strobe = (state_d == sram_host_pkg::ST_STROBE); // RULE_01 RULE_03 RULE_04
    wire logic nxt_rd = (state_d == sram_host_pkg::ST_ACCESS);
    wire logic nxt_write = take_req ? req_write_in : write_q;
    wire logic [1:0] nxt_lane = take_req ? lane_sel : lane_q;
    // select deasserts after hold or turn, strobes already high
    wire logic nxt_cs_n = !nxt_cs; // RULE_17 RULE_18
    // gate low only in reads, so a write never fights the device
    wire logic nxt_oe_n = !nxt_rd || nxt_write; // RULE_05 RULE_16
    // only the enabled lane strobes; the other keeps its byte
    wire logic [1:0] nxt_we_n = ~({2{nxt_strobe && nxt_write}} & nxt_lane); // RULE_19 RULE_24
    wire logic nxt_drive = nxt_write && nxt_cs;
    wire logic capture = (state_q == sram_host_pkg::ST_ACCESS) && timer_done;

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= sram_host_pkg::ST_IDLE;
            cs_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 2'h3;
            drive_q <= 1'b0;
            rsp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cs_n_q <= nxt_cs_n;
            oe_n_q <= nxt_oe_n;
            we_n_q <= nxt_we_n;
            drive_q <= nxt_drive;
            rsp_q <= (state_d == sram_host_pkg::ST_DONE);
        end
    end

    // address and data only move while idle, strobes high
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_q <= '0;
            wdata_q <= '0;
            lane_q <= 2'h3;
            write_q <= 1'b0;
        end else if (take_req) begin // RULE_02 RULE_15
            addr_q <= req_addr_in;
            wdata_q <= req_wdata_in;
            lane_q <= lane_sel;
            write_q <= req_write_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) rdata_q <= '0;
        else if (capture) rdata_q <= data_pins_in;
    end

    // strap resampled on every clock once out of reset
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) relaxed_q <= 1'b0;
        else relaxed_q <= guard_pin_strap_in; // RULE_21
    end

    cycle_timer #(
        .CNT_W(sram_host_pkg::CNT_W)
    ) u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .expired_out(timer_done)
    );

    // ==========================================================
    // outputs
    // strobe-controlled writes only; select-controlled form unused
    assign word_addr_lines_out = addr_q; // RULE_12 RULE_13 RULE_14
    assign chip_select_n_out = cs_n_q;
    assign output_drive_gate_n_out = oe_n_q;
    assign byte_lane0_wr_strobe_out = we_n_q[0];
    assign byte_lane1_wr_strobe_out = we_n_q[1];
    assign data_pins_out = wdata_q;
    assign data_pins_oe_out = {DATA_W{drive_q}}; // RULE_20
    assign req_ready_out = in_idle;
    assign rsp_valid_out = rsp_q;
    assign rsp_rdata_out = rdata_q;
    assign relaxed_timing_select_out = relaxed_q;
endmodule // sram_write_host

// file: testbench/sram_device_model.sv
`timescale 1ns/100ps
// ==========================================
// behavioural 8k x 16 memory on the pins
module sram_device_model (
    input wire logic clk_in,
    input wire logic cs_n_in,
    input wire logic gate_n_in,
    input wire logic lane0_n_in,
    input wire logic lane1_n_in,
    input wire logic [12:0] addr_in,
    input wire logic [15:0] bus_in,
    output logic [15:0] bus_out
);
    logic [15:0] mem [0:8191];
    logic tick = 1'b0;
    wire logic act0 = !cs_n_in && !lane0_n_in;
    wire logic act1 = !cs_n_in && !lane1_n_in;
    wire logic rd_ok = !cs_n_in && !gate_n_in;
    // released lanes toggle, so a stale byte never reads as good
    wire logic [7:0] junk = {8{tick}} ^ 8'h5a;
    always @(posedge clk_in) tick <= !tick;
    // latch at the first rise of select or strobe
    always @(negedge act0) mem[addr_in][7:0] <= bus_in[7:0];
    always @(negedge act1) mem[addr_in][15:8] <= bus_in[15:8];
    // written lane floats, the other lane reads
    assign bus_out[7:0] = (rd_ok && lane0_n_in) ? mem[addr_in][7:0] : junk;
    assign bus_out[15:8] = (rd_ok && lane1_n_in) ? mem[addr_in][15:8] : ~junk;
endmodule // sram_device_model

// file: testbench/sram_write_host_monitor.sv
`timescale 1ns/100ps
// ==========================================
// pin protocol checks
module sram_write_host_monitor (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_lane_en_in,
    input wire logic guard_pin_strap_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [15:0] rsp_rdata_out,
    input wire logic relaxed_timing_select_out,
    input wire logic [12:0] word_addr_lines_out,
    input wire logic chip_select_n_out,
    input wire logic output_drive_gate_n_out,
    input wire logic byte_lane0_wr_strobe_out,
    input wire logic byte_lane1_wr_strobe_out,
    input wire logic [15:0] data_pins_in,
    input wire logic [15:0] data_pins_out,
    input wire logic [15:0] data_pins_oe_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [1:0] lane_q;
    wire logic cs = !chip_select_n_out;
    wire logic any_lo = !byte_lane0_wr_strobe_out || !byte_lane1_wr_strobe_out;
    // empty mask means whole word
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lane_q <= 2'h3;
        end else if (req_valid_in && req_ready_out) begin
            lane_q <= (req_lane_en_in == 2'h0) ? 2'h3 : req_lane_en_in;
        end
    end
    sequence wr_take; req_valid_in && req_ready_out && req_write_in; endsequence
    sequence rd_take; req_valid_in && req_ready_out && !req_write_in; endsequence
    sequence wr_open; cs && !any_lo && data_pins_oe_out != 16'h0; endsequence
    sequence wr_pulse;
        cs && {byte_lane1_wr_strobe_out, byte_lane0_wr_strobe_out} == ~lane_q;
    endsequence
    sequence wr_end; !cs && rsp_valid_out && data_pins_oe_out == 16'h0; endsequence
    sequence rd_open; cs && !output_drive_gate_n_out && !any_lo; endsequence
    a_write_walk: assert property (wr_take |=> wr_open ##1 wr_pulse ##1 wr_open ##1 wr_end)
        else $error("write pin sequence wrong");
    a_read_walk: assert property (rd_take |=> rd_open ##1 (cs && output_drive_gate_n_out)
        ##1 (!cs && rsp_valid_out)) else $error("read pin sequence wrong");
    a_lane_pick: assert property (any_lo |-> wr_pulse)
        else $error("strobe lanes differ from mask");
    a_strobe_gated: assert property (any_lo |-> cs && output_drive_gate_n_out)
        else $error("strobe low outside select or with gate low");
    a_no_contend: assert property (!output_drive_gate_n_out |-> data_pins_oe_out == 16'h0)
        else $error("host drives while memory outputs enabled");
    a_addr_steady: assert property (cs && $past(cs) |-> $stable(word_addr_lines_out))
        else $error("address moved while selected");
    a_data_steady: assert property (cs && $past(cs) && data_pins_oe_out != 16'h0
        && $past(data_pins_oe_out) != 16'h0 |-> $stable(data_pins_out))
        else $error("write data moved while selected");
    a_strap_copy: assert property ($past(reset_n_in) |->
        relaxed_timing_select_out == $past(guard_pin_strap_in)) else $error("timing select lags");
    a_rdata_take: assert property ($rose(output_drive_gate_n_out) |=>
        rsp_valid_out && rsp_rdata_out == $past(data_pins_in, 2)) else $error("read data lost");
endmodule // sram_write_host_monitor

// file: testbench/sram_write_host_tb.sv
`timescale 1ns/100ps
// ==========================================
// random word and byte writes with readback
module sram_write_host_tb;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [12:0] req_addr_in = 13'h0;
    logic [15:0] req_wdata_in = 16'h0;
    logic [1:0] req_lane_en_in = 2'h0;
    logic guard_pin_strap_in = 1'b0;
    logic req_ready_out, rsp_valid_out, relaxed_timing_select_out;
    logic [15:0] rsp_rdata_out, data_pins_out, data_pins_oe_out, dev_q;
    logic [12:0] word_addr_lines_out;
    logic chip_select_n_out, output_drive_gate_n_out;
    logic byte_lane0_wr_strobe_out, byte_lane1_wr_strobe_out;
    wire logic [15:0] data_pins_in = (data_pins_oe_out & data_pins_out) | (~data_pins_oe_out & dev_q);
    int n_errors = 0;
    int total_checks = 0;
    logic [15:0] seed = 16'h005a;
    sram_write_host uut (.sys_clk_in, .reset_n_in, .req_valid_in, .req_write_in, .req_addr_in,
        .req_wdata_in, .req_lane_en_in, .guard_pin_strap_in, .req_ready_out, .rsp_valid_out,
        .rsp_rdata_out, .relaxed_timing_select_out, .word_addr_lines_out, .chip_select_n_out,
        .output_drive_gate_n_out, .byte_lane0_wr_strobe_out, .byte_lane1_wr_strobe_out,
        .data_pins_in, .data_pins_out, .data_pins_oe_out);
    sram_device_model dev (.clk_in(sys_clk_in), .cs_n_in(chip_select_n_out),
        .gate_n_in(output_drive_gate_n_out), .lane0_n_in(byte_lane0_wr_strobe_out),
        .lane1_n_in(byte_lane1_wr_strobe_out), .addr_in(word_addr_lines_out),
        .bus_in(data_pins_in), .bus_out(dev_q));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
        input logic [1:0] ln);
        logic [1:0] m;
        m = (ln == 2'h0) ? 2'h3 : ln;
        return {m[1] ? n[15:8] : o[15:8], m[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one request, held until taken, then a bounded wait for the answer
    task automatic xfer(input logic w, input logic [12:0] a, input logic [15:0] d,
        input logic [1:0] ln, output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        seed = lfsr(seed);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        req_lane_en_in <= ln;
        guard_pin_strap_in <= seed[0];
        do @(posedge sys_clk_in); while (!req_ready_out);
        req_valid_in <= 1'b0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (!rsp_valid_out && n < 20);
        rd = rsp_rdata_out;
        check("latency", w ? 16'h4 : 16'h3, 16'(n));
        check("relaxed", {15'h0, guard_pin_strap_in}, {15'h0, relaxed_timing_select_out});
    endtask
    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // far beyond the expected run of under a thousand cycles
    initial begin
        #(50 * 4000);
        n_errors++;
        give_verdict();
    end
    initial begin
        logic [15:0] d1, d2, got;
        logic [12:0] a;
        logic [1:0] ln;
        repeat (12) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            d1 = seed;
            seed = lfsr(seed);
            d2 = seed;
            a = (i < 4) ? 13'h0 : (i < 8) ? 13'h1fff : seed[12:0];
            ln = (i < 8) ? i[1:0] : d1[1:0];
            xfer(1'b1, a, d1, 2'h3, got);
            xfer(1'b1, ~a, ~d1, 2'h3, got);
            xfer(1'b1, a, d2, ln, got);
            xfer(1'b0, a, d1 ^ d2, ln, got);
            check("readback", merge(d1, d2, ln), got);
            $display("test %0d addr %h lanes %0d done", i, a, ln);
        end
        give_verdict();
    end
endmodule // sram_write_host_tb
bind sram_write_host sram_write_host_monitor mon (.sys_clk_in, .reset_n_in, .req_valid_in,
    .req_write_in, .req_lane_en_in, .guard_pin_strap_in, .req_ready_out, .rsp_valid_out,
    .rsp_rdata_out, .relaxed_timing_select_out, .word_addr_lines_out, .chip_select_n_out,
    .output_drive_gate_n_out, .byte_lane0_wr_strobe_out, .byte_lane1_wr_strobe_out,
    .data_pins_in, .data_pins_out, .data_pins_oe_out);
